// ---- tlic_params.svh ----
// register offsets, field positions, reset values and vector addresses of the interrupt controller
`ifndef TLIC_PARAMS_SVH
`define TLIC_PARAMS_SVH
`define TLIC_ADDR_TCTL 8'h88
`define TLIC_ADDR_SCTL 8'h98
`define TLIC_ADDR_EN 8'ha8
`define TLIC_ADDR_LVL 8'hb8
`define TLIC_ADDR_FLAGS 8'hfa
`define TLIC_BIT_EXT0_SEL 0
`define TLIC_BIT_EXT0_FLAG 1
`define TLIC_BIT_EXT1_SEL 2
`define TLIC_BIT_EXT1_FLAG 3
`define TLIC_BIT_T0_FLAG 5
`define TLIC_BIT_T1_FLAG 7
`define TLIC_BIT_RX_FLAG 0
`define TLIC_BIT_TX_FLAG 1
`define TLIC_BIT_PWM_FLAG 0
`define TLIC_BIT_MMT_FLAG 1
`define TLIC_BIT_P54 6
`define TLIC_BIT_P53 7
`define TLIC_BIT_GATE 7
`define TLIC_RST_TCTL 8'h00
`define TLIC_RST_SCTL 8'h00
`define TLIC_RST_EN 8'h00
`define TLIC_RST_LVL 8'h00
`define TLIC_RST_FLAGS 8'h00
`define TLIC_EN_MASK 8'hbf
`define TLIC_LVL_MASK 8'h3f
`define TLIC_VEC_EXT0 8'h03
`define TLIC_VEC_T0 8'h0b
`define TLIC_VEC_EXT1 8'h13
`define TLIC_VEC_T1 8'h1b
`define TLIC_VEC_SER 8'h23
`define TLIC_VEC_PWM 8'h2b
`endif

// ---- tlic_pkg.sv ----
// types shared by the interrupt controller
package tlic_pkg;
  typedef struct packed {
    logic wr;
    logic rd;
    logic bit_op;
    logic [7:0] addr;
    logic [2:0] bit_sel;
    logic [7:0] wdata;
  } tlic_sfr_req_t;
  typedef struct packed {
    logic timer0_overflow;
    logic timer0_mode3;
    logic timer1_overflow;
    logic serial_rx_done;
    logic serial_tx_done;
    logic pwm_event;
    logic mmt_event;
    logic display_event;
  } tlic_src_t;
  typedef struct packed {
    logic req;
    logic [7:0] vector;
    logic high;
  } tlic_core_req_t;
endpackage

// ---- tlic_top.sv ----
// two level interrupt request, enable, priority and vectoring logic
// Summary of operation
// RL1: timer control holds ext0 flag bit1, timer0 bit5, ext1/display bit3, timer1 bit7.
// RL2: serial control holds receive flag bit0, transmit bit1; either raises serial vector.
// RL3: timer overflow sets its flag, except timer 0 in mode 3.
// RL4: pwm/multi-mode vector request is the OR of both flags, vector 2b.
// RL5: flag register bit0 pwm flag, bit1 multi-mode flag, set by their sources.
// RL6: pwm and multi-mode flags stay set on vector entry until software clears.
// RL7: flag register bit7 port5 line3, bit6 line4, bits 2-5 reserved, resets 00.
// RL8: software writes set or clear every request flag like hardware does; level-mode ext0/ext1 flags follow the pin and ignore writes.
// RL9: request acknowledged only when individually enabled, serviced at its selected level.
// RL10: enable register bits 0-5 enable the six vectors, bit 6 reserved.
// RL11: enable bit 7 gates all interrupts globally.
// RL12: timer, enable, level and serial registers bit-addressable; flag register byte only.
// RL13: each vector takes one of two levels; nesting at most two deep.
// RL14: software selects level or transition activation per external input.
// RL15: vectors 03, 0b, 13, 1b, 23, 2b in source order.
// RL16: high level preempts low service; same or higher level never preempted.
// RL17: equal level ties resolved ext0, timer0, ext1, timer1, serial, pwm/mmt.
// RL18: select bit 1 gives falling edge trigger, 0 gives low level trigger.
// RL19: request held until core acknowledges; active level recorded until return.
`timescale 1ns/1ps
`include "tlic_params.svh"
module tlic_top (
  input wire logic clock, // core clock
  input wire logic rst, // asynchronous reset, active high
  input wire tlic_pkg::tlic_sfr_req_t sfr_req, // special function register access
  output logic [7:0] sfr_rdata, // read data of the addressed register
  output logic sfr_hit, // address belongs to this block
  input wire logic ext0_line, // external request 0 input
  input wire logic ext1_line, // external request 1 input
  input wire logic port5_line3_input, // port 5 line 3
  input wire logic port5_line4_input, // port 5 line 4
  input wire tlic_pkg::tlic_src_t src, // peripheral event pulses
  output tlic_pkg::tlic_core_req_t core_req, // request presented to the core
  input wire logic core_ack, // core takes the presented vector
  input wire logic core_reti // core returns from interrupt
);
  import tlic_pkg::*;

  typedef enum logic [2:0] {
    TLIC_IDLE = 3'b001,
    TLIC_PRESENT = 3'b010,
    TLIC_HOLD = 3'b100
  } tlic_state_t;

  logic [7:0] timer_and_ext_request_control, next_timer_and_ext_request_control;
  logic [7:0] serial_port_control, next_serial_port_control;
  logic [7:0] irq_enable_mask, next_irq_enable_mask;
  logic [7:0] irq_level_select, next_irq_level_select;
  logic [1:0] shared_irq_flags, next_shared_irq_flags;
  logic ext0_prev, ext1_prev;
  logic next_ext0_prev, next_ext1_prev;
  // bit 1: a high level routine runs, bit 0: a low level routine runs
  logic [1:0] active_level, next_active_level;
  tlic_state_t state, next_state;
  logic [2:0] sel_idx, next_sel_idx;
  logic sel_high, next_sel_high;
  logic [7:0] sel_vector, next_sel_vector;

  logic [5:0] pending;
  logic [5:0] eligible;
  logic win_found;
  logic [2:0] win_idx;
  logic win_high;

  // merge a whole-byte or single-bit write into a register value
  function automatic logic [7:0] sfr_merge(input logic [7:0] cur, input tlic_sfr_req_t r);
    logic [7:0] res;
    res = cur;
    if (r.bit_op) begin
      res[r.bit_sel] = r.wdata[0];
    end else begin
      res = r.wdata;
    end
    return res;
  endfunction

  function automatic logic [7:0] vec_of(input logic [2:0] idx);
    logic [7:0] v;
    unique case (idx)
      3'h0: v = `TLIC_VEC_EXT0; // RL15
      3'h1: v = `TLIC_VEC_T0;
      3'h2: v = `TLIC_VEC_EXT1;
      3'h3: v = `TLIC_VEC_T1;
      3'h4: v = `TLIC_VEC_SER;
      default: v = `TLIC_VEC_PWM; // RL4
    endcase
    return v;
  endfunction

  // write strobe for one register address
  function automatic logic wr_to(input tlic_sfr_req_t r, input logic [7:0] a);
    return r.wr && r.addr == a;
  endfunction

  logic wr_tctl, wr_sctl, wr_en, wr_lvl, wr_flags;
  logic ext0_fall, ext1_fall;
  logic take_ext0, take_t0, take_ext1, take_t1;

  // register write strobes, pin edges and vector entry for ext0, timer0, ext1 and timer1
  always_comb begin
    wr_tctl = wr_to(sfr_req, `TLIC_ADDR_TCTL);
    wr_sctl = wr_to(sfr_req, `TLIC_ADDR_SCTL);
    wr_en = wr_to(sfr_req, `TLIC_ADDR_EN);
    wr_lvl = wr_to(sfr_req, `TLIC_ADDR_LVL);
    wr_flags = wr_to(sfr_req, `TLIC_ADDR_FLAGS) && !sfr_req.bit_op; // RL12
    ext0_fall = ext0_prev && !ext0_line;
    ext1_fall = ext1_prev && !ext1_line;
    take_ext0 = core_ack && state == TLIC_PRESENT && sel_idx == 3'h0;
    take_t0 = core_ack && state == TLIC_PRESENT && sel_idx == 3'h1;
    take_ext1 = core_ack && state == TLIC_PRESENT && sel_idx == 3'h2;
    take_t1 = core_ack && state == TLIC_PRESENT && sel_idx == 3'h3;
  end

  // request flag registers; hardware set wins over any clear in the same cycle
  always_comb begin
    next_timer_and_ext_request_control = timer_and_ext_request_control;
    next_serial_port_control = serial_port_control;
    next_shared_irq_flags = shared_irq_flags;
    if (wr_tctl) begin
      next_timer_and_ext_request_control = sfr_merge(timer_and_ext_request_control, sfr_req); // RL8 RL12
    end
    if (wr_sctl) begin
      next_serial_port_control = sfr_merge(serial_port_control, sfr_req); // RL8 RL12
    end
    if (wr_flags) begin
      next_shared_irq_flags = {sfr_req.wdata[`TLIC_BIT_MMT_FLAG], sfr_req.wdata[`TLIC_BIT_PWM_FLAG]}; // RL8
    end
    // edge-triggered external flags and timer flags clear on vector entry
    if (take_ext0 && timer_and_ext_request_control[`TLIC_BIT_EXT0_SEL]) begin
      next_timer_and_ext_request_control[`TLIC_BIT_EXT0_FLAG] = 1'b0;
    end
    if (take_ext1 && timer_and_ext_request_control[`TLIC_BIT_EXT1_SEL]) begin
      next_timer_and_ext_request_control[`TLIC_BIT_EXT1_FLAG] = 1'b0;
    end
    if (take_t0) begin
      next_timer_and_ext_request_control[`TLIC_BIT_T0_FLAG] = 1'b0;
    end
    if (take_t1) begin
      next_timer_and_ext_request_control[`TLIC_BIT_T1_FLAG] = 1'b0;
    end
    // level mode tracks the pin; edge mode latches a falling edge
    if (timer_and_ext_request_control[`TLIC_BIT_EXT0_SEL]) begin // RL14
      if (ext0_fall) begin
        next_timer_and_ext_request_control[`TLIC_BIT_EXT0_FLAG] = 1'b1; // RL18
      end
    end else begin
      next_timer_and_ext_request_control[`TLIC_BIT_EXT0_FLAG] = !ext0_line; // RL18
    end
    if (timer_and_ext_request_control[`TLIC_BIT_EXT1_SEL]) begin // RL14
      if (ext1_fall || src.display_event) begin
        next_timer_and_ext_request_control[`TLIC_BIT_EXT1_FLAG] = 1'b1; // RL18
      end
    end else begin
      next_timer_and_ext_request_control[`TLIC_BIT_EXT1_FLAG] = !ext1_line || src.display_event; // RL18
    end
    if (src.timer0_overflow && !src.timer0_mode3) begin
      next_timer_and_ext_request_control[`TLIC_BIT_T0_FLAG] = 1'b1; // RL3 RL1
    end
    if (src.timer1_overflow) begin
      next_timer_and_ext_request_control[`TLIC_BIT_T1_FLAG] = 1'b1; // RL3 RL1
    end
    if (src.serial_rx_done) begin
      next_serial_port_control[`TLIC_BIT_RX_FLAG] = 1'b1; // RL2
    end
    if (src.serial_tx_done) begin
      next_serial_port_control[`TLIC_BIT_TX_FLAG] = 1'b1; // RL2
    end
    // no clear on vector entry for these two
    if (src.pwm_event) begin
      next_shared_irq_flags[0] = 1'b1; // RL5 RL6
    end
    if (src.mmt_event) begin
      next_shared_irq_flags[1] = 1'b1; // RL5 RL6
    end
  end

  // configuration registers; reserved bits always read back as zero
  always_comb begin
    next_irq_enable_mask = irq_enable_mask;
    next_irq_level_select = irq_level_select;
    if (wr_en) begin
      next_irq_enable_mask = sfr_merge(irq_enable_mask, sfr_req) & `TLIC_EN_MASK; // RL10
    end
    if (wr_lvl) begin
      next_irq_level_select = sfr_merge(irq_level_select, sfr_req) & `TLIC_LVL_MASK; // RL13
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      timer_and_ext_request_control <= `TLIC_RST_TCTL;
      serial_port_control <= `TLIC_RST_SCTL;
      shared_irq_flags <= 2'(`TLIC_RST_FLAGS); // RL7
    end else begin
      timer_and_ext_request_control <= next_timer_and_ext_request_control;
      serial_port_control <= next_serial_port_control;
      shared_irq_flags <= next_shared_irq_flags;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      irq_enable_mask <= `TLIC_RST_EN;
      irq_level_select <= `TLIC_RST_LVL;
    end else begin
      irq_enable_mask <= next_irq_enable_mask;
      irq_level_select <= next_irq_level_select;
    end
  end

  // pin history for the falling edge detectors; reset to the idle high level so no false edge follows reset
  always_comb begin
    next_ext0_prev = ext0_line;
    next_ext1_prev = ext1_line;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ext0_prev <= 1'b1;
      ext1_prev <= 1'b1;
    end else begin
      ext0_prev <= next_ext0_prev;
      ext1_prev <= next_ext1_prev;
    end
  end

  // arbitration: level first, then fixed polling order
  always_comb begin
    pending[0] = timer_and_ext_request_control[`TLIC_BIT_EXT0_FLAG]; // RL1
    pending[1] = timer_and_ext_request_control[`TLIC_BIT_T0_FLAG];
    pending[2] = timer_and_ext_request_control[`TLIC_BIT_EXT1_FLAG];
    pending[3] = timer_and_ext_request_control[`TLIC_BIT_T1_FLAG];
    pending[4] = serial_port_control[`TLIC_BIT_RX_FLAG] | serial_port_control[`TLIC_BIT_TX_FLAG]; // RL2
    pending[5] = shared_irq_flags[0] | shared_irq_flags[1]; // RL4
    eligible = pending & irq_enable_mask[5:0] & {6{irq_enable_mask[`TLIC_BIT_GATE]}}; // RL9 RL11
    win_found = 1'b0;
    win_idx = 3'h0;
    win_high = 1'b0;
    // high level may start unless a high routine runs; low only when idle
    for (int i = 5; i >= 0; i--) begin
      if (eligible[i] && irq_level_select[i] && !active_level[1]) begin // RL16 RL17
        win_found = 1'b1;
        win_idx = 3'(i);
        win_high = 1'b1;
      end
    end
    if (!win_found) begin
      for (int i = 5; i >= 0; i--) begin
        if (eligible[i] && !irq_level_select[i] && active_level == 2'b00) begin // RL16 RL17
          win_found = 1'b1;
          win_idx = 3'(i);
          win_high = 1'b0;
        end
      end
    end
  end

  always_comb begin
    next_state = state;
    next_sel_idx = sel_idx;
    next_sel_high = sel_high;
    next_sel_vector = sel_vector;
    next_active_level = active_level;
    // a return clears only the highest active level
    if (core_reti) begin
      if (active_level[1]) begin
        next_active_level[1] = 1'b0; // RL13
      end else begin
        next_active_level[0] = 1'b0;
      end
    end
    unique case (state)
      TLIC_IDLE: begin
        if (win_found) begin
          next_state = TLIC_PRESENT;
          next_sel_idx = win_idx;
          next_sel_high = win_high; // RL9
          next_sel_vector = vec_of(win_idx); // RL15
        end
      end
      TLIC_PRESENT: begin
        if (core_ack) begin // RL19
          next_state = TLIC_HOLD;
          if (sel_high) begin
            next_active_level[1] = 1'b1; // RL19
          end else begin
            next_active_level[0] = 1'b1; // RL19
          end
        end else if (!win_found) begin
          next_state = TLIC_IDLE; // request withdrawn by software or by a level-triggered external flag falling
        end else begin
          next_sel_idx = win_idx;
          next_sel_high = win_high;
          next_sel_vector = vec_of(win_idx);
        end
      end
      TLIC_HOLD: begin
        // one cycle so the cleared flag is not presented again
        next_state = TLIC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state <= TLIC_IDLE;
      sel_idx <= 3'h0;
      sel_high <= 1'b0;
      sel_vector <= 8'h00;
      active_level <= 2'b00;
    end else begin
      state <= next_state;
      sel_idx <= next_sel_idx;
      sel_high <= next_sel_high;
      sel_vector <= next_sel_vector;
      active_level <= next_active_level;
    end
  end

  // request, vector and level all come from registered state
  always_comb begin
    core_req.req = state == TLIC_PRESENT; // RL19
    core_req.vector = sel_vector;
    core_req.high = sel_high;
  end

  // reads are combinational so the addressed register shows in the same cycle
  always_comb begin
    sfr_hit = 1'b1;
    unique case (sfr_req.addr)
      `TLIC_ADDR_TCTL: sfr_rdata = timer_and_ext_request_control;
      `TLIC_ADDR_SCTL: sfr_rdata = serial_port_control;
      `TLIC_ADDR_EN: sfr_rdata = irq_enable_mask;
      `TLIC_ADDR_LVL: sfr_rdata = irq_level_select;
      `TLIC_ADDR_FLAGS: sfr_rdata = {port5_line3_input, port5_line4_input, 4'h0, shared_irq_flags}; // RL7
      default: begin
        sfr_rdata = 8'h00;
        sfr_hit = 1'b0;
      end
    endcase
  end
endmodule // tlic_top

// ---- tlic_checker.sv ----
// port assertions of the two level interrupt controller
`timescale 1ns/1ps
module tlic_checker (
  input wire logic clock, // core clock
  input wire logic rst, // async reset
  input wire tlic_pkg::tlic_sfr_req_t sfr_req, // register access
  input wire logic [7:0] sfr_rdata, // read data
  input wire logic sfr_hit, // address hit
  input wire tlic_pkg::tlic_core_req_t core_req, // request to core
  input wire logic core_ack, // core takes vector
  input wire logic core_reti // return from interrupt
);
  import tlic_pkg::*;
  logic [7:0] en_q;
  logic [1:0] act_q;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  // shadow of the enable register and of the level-active flops
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      en_q <= 8'h00;
      act_q <= 2'h0;
    end else begin
      if (sfr_req.wr && sfr_req.addr == 8'ha8) begin
        if (sfr_req.bit_op) en_q[sfr_req.bit_sel] <= sfr_req.wdata[0];
        else en_q <= sfr_req.wdata;
      end
      if (core_ack && core_req.req) act_q[core_req.high] <= 1'h1;
      else if (core_reti) act_q <= act_q[1] ? {1'h0, act_q[0]} : 2'h0;
    end
  end
  a_hit_decode: assert property (sfr_hit == (sfr_req.addr inside {8'h88, 8'h98, 8'ha8, 8'hb8, 8'hfa}))
    else $error("hit decode wrong");
  a_unmapped_zero: assert property (!sfr_hit |-> sfr_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_flag_reserved: assert property (sfr_req.addr == 8'hfa |-> sfr_rdata[5:2] == 4'h0)
    else $error("flag reserved bits set");
  a_enable_reserved: assert property (sfr_req.addr == 8'ha8 |-> !sfr_rdata[6])
    else $error("enable bit 6 set");
  a_gate_blocks: assert property ($rose(core_req.req) |-> $past(en_q[7]))
    else $error("request with gate off");
  a_vector_table: assert property (core_req.req |-> core_req.vector inside {8'h03, 8'h0b, 8'h13, 8'h1b, 8'h23, 8'h2b})
    else $error("bad vector");
  a_ack_release: assert property (core_req.req && core_ack |=> !core_req.req)
    else $error("request held after ack");
  a_high_blocks: assert property (act_q[1] |-> !core_req.req)
    else $error("request during high service");
  a_low_blocks: assert property (act_q[0] |-> !core_req.req || core_req.high)
    else $error("low request during low service");
endmodule // tlic_checker
bind tlic_top tlic_checker u_chk (.clock(clock), .rst(rst), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
  .sfr_hit(sfr_hit), .core_req(core_req), .core_ack(core_ack), .core_reti(core_reti));

// ---- tlic_core_model.sv ----
// behavioural processor core that takes and returns from interrupts
`timescale 1ns/1ps
module tlic_core_model (
  input wire logic clock, // core clock
  input wire logic rst, // async reset
  input wire tlic_pkg::tlic_core_req_t core_req, // presented request
  input wire logic [3:0] ack_delay, // wait before taking
  input wire logic reti_cmd, // bench asks for a return
  output logic core_ack, // take pulse
  output logic core_reti, // return pulse
  output logic [7:0] taken_vec, // last vector taken
  output logic taken_high, // level of last take
  output logic [7:0] taken_n // number of takes
);
  import tlic_pkg::*;
  logic [3:0] wait_q;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      core_ack <= 1'h0;
      core_reti <= 1'h0;
      wait_q <= 4'h0;
      taken_vec <= 8'h00;
      taken_high <= 1'h0;
      taken_n <= 8'h00;
    end else begin
      core_ack <= 1'h0;
      core_reti <= reti_cmd;
      wait_q <= 4'h0;
      if (core_ack && core_req.req) begin
        taken_vec <= core_req.vector;
        taken_high <= core_req.high;
        taken_n <= taken_n + 8'h01;
      end
      // take only while the request is still presented
      if (core_req.req && !core_ack) begin
        wait_q <= wait_q + 4'h1;
        if (wait_q >= ack_delay) begin
          core_ack <= 1'h1;
          wait_q <= 4'h0;
        end
      end
    end
  end
endmodule // tlic_core_model

// ---- tb_top.sv ----
// self-checking bench for the interrupt controller
`timescale 1ns/1ps
module tb_top;
  import tlic_pkg::*;
  logic clock, rst, ext0_line, ext1_line, port5_line3_input, port5_line4_input, core_ack, core_reti, sfr_hit;
  logic reti_cmd, taken_high;
  logic [3:0] ack_delay;
  logic [7:0] sfr_rdata, taken_vec, taken_n, n0, pf, fl;
  logic [5:0] pend, en, lv;
  tlic_sfr_req_t sfr_req;
  tlic_src_t src;
  tlic_core_req_t core_req;
  int n_mismatch = 0, checked = 0, w, rnd;
  tlic_top DUT (.clock(clock), .rst(rst), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit),
    .ext0_line(ext0_line), .ext1_line(ext1_line), .port5_line3_input(port5_line3_input),
    .port5_line4_input(port5_line4_input), .src(src), .core_req(core_req), .core_ack(core_ack), .core_reti(core_reti));
  tlic_core_model core (.clock(clock), .rst(rst), .core_req(core_req), .ack_delay(ack_delay), .reti_cmd(reti_cmd),
    .core_ack(core_ack), .core_reti(core_reti), .taken_vec(taken_vec), .taken_high(taken_high), .taken_n(taken_n));
  task automatic final_report();
    if (n_mismatch == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic b = 1'h0, input logic [2:0] s = 3'h0);
    @(posedge clock);
    sfr_req <= '{wr: 1'h1, rd: 1'h0, bit_op: b, addr: a, bit_sel: s, wdata: d};
    @(posedge clock);
    sfr_req.wr <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock);
    sfr_req.addr <= a;
    @(negedge clock);
    chk(sfr_rdata, exp);
  endtask
  task automatic pulse(input tlic_src_t s);
    @(posedge clock);
    src <= s;
    @(posedge clock);
    src <= '0;
  endtask
  task automatic ret_irq();
    @(posedge clock);
    reti_cmd <= 1'h1;
    @(posedge clock);
    reti_cmd <= 1'h0;
  endtask
  task automatic wait_take(input logic [7:0] n);
    for (int i = 0; i < 40 && taken_n === n; i++) @(posedge clock);
  endtask
  function automatic logic [7:0] vec(input int i);
    return 8'h03 + 8'(8 * i);
  endfunction
  // winner: lowest index among high-level requests, else lowest index overall
  function automatic int pick(input logic [5:0] p, input logic [5:0] l);
    pick = 7;
    for (int i = 5; i >= 0; i--) if (p[i] && l[i]) pick = i;
    if (pick == 7) for (int i = 5; i >= 0; i--) if (p[i]) pick = i;
  endfunction
  initial begin
    clock = 1'h0;
    forever #4 clock = ~clock;
  end
  initial begin
    repeat (30000) @(posedge clock);
    n_mismatch++;
    final_report();
  end
  initial begin
    rnd = $urandom(90154);
    rst = 1'h1;
    sfr_req = '0;
    src = '0;
    ext0_line = 1'h1;
    ext1_line = 1'h1;
    reti_cmd = 1'h0;
    ack_delay = 4'h0;
    {port5_line3_input, port5_line4_input} = 2'($urandom);
    pf = {port5_line3_input, port5_line4_input, 6'h00};
    repeat (5) @(posedge clock);
    rst <= 1'h0;
    rd(8'h88, 8'h00);
    rd(8'h98, 8'h00);
    rd(8'ha8, 8'h00);
    chk({7'h00, sfr_hit}, 8'h01);
    rd(8'hfa, pf);
    rd(8'h90, 8'h00);
    chk({7'h00, sfr_hit}, 8'h00);
    wr(8'hb8, 8'hff);
    rd(8'hb8, 8'h3f);
    wr(8'hfa, 8'hff);
    rd(8'hfa, pf | 8'h03);
    wr(8'hfa, 8'h00, 1'h1);
    rd(8'hfa, pf | 8'h03);
    wr(8'hfa, 8'h00);
    wr(8'ha8, 8'hff);
    rd(8'ha8, 8'hbf);
    wr(8'ha8, 8'h00, 1'h1, 3'h7);
    rd(8'ha8, 8'h3f);
    wr(8'ha8, 8'h00);
    @(posedge clock);
    ext1_line <= 1'h0;
    rd(8'h88, 8'h08);
    @(posedge clock);
    ext1_line <= 1'h1;
    rd(8'h88, 8'h00);
    wr(8'h88, 8'h05);
    pulse('{timer1_overflow: 1'h1, default: 1'h0});
    rd(8'h88, 8'h85);
    pulse('{timer0_overflow: 1'h1, timer0_mode3: 1'h1, default: 1'h0});
    rd(8'h88, 8'h85);
    pulse('{timer0_overflow: 1'h1, default: 1'h0});
    rd(8'h88, 8'ha5);
    pulse('{display_event: 1'h1, default: 1'h0});
    rd(8'h88, 8'had);
    @(posedge clock);
    ext0_line <= 1'h0;
    repeat (2) @(posedge clock);
    ext0_line <= 1'h1;
    rd(8'h88, 8'haf);
    pulse('{serial_tx_done: 1'h1, default: 1'h0});
    rd(8'h98, 8'h02);
    pulse('{pwm_event: 1'h1, mmt_event: 1'h1, default: 1'h0});
    rd(8'hfa, pf | 8'h03);
    for (int k = 0; k < 40; k++) begin
      wr(8'h88, 8'h05);
      wr(8'h98, 8'h00);
      wr(8'hfa, 8'h00);
      pend = (k == 0) ? 6'h3f : 6'($urandom);
      en = (k == 0) ? 6'h3f : 6'($urandom);
      lv = (k < 2) ? 6'h00 : 6'($urandom);
      ack_delay <= 4'($urandom);
      wr(8'hb8, {2'h0, lv});
      wr(8'h88, 8'h05 | {pend[3], 1'h0, pend[1], 1'h0, pend[2], 1'h0, pend[0], 1'h0});
      wr(8'h98, {6'h00, pend[4] & k[0], pend[4] & !k[0]});
      fl = {6'h00, pend[5] & k[1], pend[5] & !k[1]};
      wr(8'hfa, fl);
      n0 = taken_n;
      wr(8'ha8, {k % 5 != 3, 1'h0, en});
      w = (k % 5 != 3) ? pick(pend & en, lv) : 7;
      wait_take(n0);
      chk(taken_n, n0 + 8'(w != 7));
      if (w != 7) begin
        chk(taken_vec, vec(w));
        chk({7'h00, taken_high}, {7'h00, lv[w]});
        if (!lv[w]) begin
          pend = pend & en & ((w > 3) ? 6'h3f : ~(6'h01 << w));
          w = pick(pend, 6'h3f);
          n0 = taken_n;
          wr(8'hb8, 8'h3f);
          wait_take(n0);
          chk(taken_n, n0 + 8'(w != 7));
          if (w != 7) chk(taken_vec, vec(w));
        end
      end
      rd(8'hfa, pf | fl);
      wr(8'ha8, 8'h00);
      ret_irq();
      ret_irq();
    end
    final_report();
  end
endmodule // tb_top
